/* shared/pbu_pkg.sv */
// Shared constants, types and helpers for the playback unit.
// Function
// RULE1 - Rate scaling changes requested time counter advance per reference clock cycle.
// RULE2 - Storage playback offers programmable stream delay counted in bit periods.
// RULE3 - Non-zero delay shifts streams, replayed tick and valid flag by that amount.
// RULE4 - Zero delay puts replayed tick on the requested tick cycle.
// RULE5 - Valid flag travels with the stream bits it qualifies.
// RULE6 - Delay range covers at least plus and minus half a second.
// RULE7 - Counter load and delay change never disturb each other.
// RULE8 - Commanded load sets counter to given second on next processor tick.
// RULE9 - Once loaded the counter ignores processor ticks until re-armed.
// RULE10 - Configuration selects which active incoming streams are reproduced.
// RULE11 - Start command emits streams aligned to counter or shifted by offset.
// RULE12 - Valid flag is high only for valid, correctly aligned output data.
// RULE13 - Stop command ends stream output.
// RULE14 - Output reproduces captured samples bit for bit.
// RULE15 - Output tick and clock need not align exactly with processor timing.
// RULE16 - Capture unit marks 0,1,2,4,8 or 16 of 32 streams active.
// RULE17 - Capture unit forwards only active streams.
// RULE18 - Only streams marked active are reconstructed.
// RULE19 - Any reconstructed stream routes to any output position, full crossbar.
// RULE20 - Replayed tick marks output bits captured on the second tick.
// RULE21 - Signed delay takes effect only at a second boundary.
// RULE22 - Five-bit selector per output; inactive source drives output low.
package pbu_pkg;
	// ==========================================================
	// Sizes
	localparam int          PBU_NS      = 32;
	localparam int          PBU_SW      = 5;
	localparam int          PBU_FRAC_W  = 16;
	localparam int          PBU_STEP_W  = 17;
	localparam int          PBU_SYNC_N  = 3;
	localparam int          PBU_AW      = 8;
	localparam logic [31:0] PBU_BPS_DEF = 32'h002625a0;
	// ==========================================================
	// Register map
	localparam logic [7:0] PBU_A_CTRL   = 8'h00;
	localparam logic [7:0] PBU_A_STAT   = 8'h04;
	localparam logic [7:0] PBU_A_SEC    = 8'h08;
	localparam logic [7:0] PBU_A_DELAY  = 8'h0c;
	localparam logic [7:0] PBU_A_STEP   = 8'h10;
	localparam logic [7:0] PBU_A_ACTIVE = 8'h14;
	localparam logic [7:0] PBU_A_SELECT = 8'h18;
	localparam logic [7:0] PBU_A_ROTSEC = 8'h1c;
	localparam logic [7:0] PBU_A_ROTBIT = 8'h20;
	localparam logic [2:0] PBU_A_ROUTE  = 3'h2;
	localparam int         PBU_CTRL_RUN  = 0;
	localparam int         PBU_CTRL_LOAD = 1;
	localparam int         PBU_ST_LOADED = 0;
	localparam int         PBU_ST_ARMED  = 1;
	localparam int         PBU_ST_DPEND  = 2;
	localparam int         PBU_ST_VALID  = 3;
	localparam logic [PBU_STEP_W-1:0] PBU_STEP_ONE = 17'h10000;
	localparam logic [1:0] PBU_OKAY   = 2'h0;
	localparam logic [1:0] PBU_SLVERR = 2'h2;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [31:0] sec;
		logic [31:0] bitn;
	} pbu_time_t;
	typedef struct packed {
		pbu_time_t t;
		logic      strobe;
	} pbu_fetch_t;
	typedef struct packed {
		logic [PBU_NS-1:0] data;
		logic              ok;
	} pbu_src_t;
	typedef struct packed {
		logic [PBU_NS-1:0] stream;
		logic              valid;
		logic              replayed_tick;
		logic              requested_tick;
		logic              stream_clk;
	} pbu_out_t;
	// ==========================================================
	// Helpers
	function automatic logic [31:0] pbu_wmask(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction
endpackage

/* rtl/pbu_xbar.sv */
// Any-to-any stream crossbar with per-output source selectors.
`timescale 1ns/1ps
module pbu_xbar
	import pbu_pkg::*;
(
	input  wire logic [PBU_NS-1:0]        src,
	input  wire logic [PBU_NS-1:0]        en,
	input  wire logic [PBU_NS*PBU_SW-1:0] sel,
	output wire logic [PBU_NS-1:0]        y
);
	// ==========================================================
	// Routing
	genvar i;
	generate
		for (i = 0; i < PBU_NS; i++) begin : g_out
			wire [PBU_SW-1:0] s = sel[i*PBU_SW +: PBU_SW];
			assign y[i] = en[s] & src[s]; // RULE19 RULE22
		end
	endgenerate
endmodule

/* rtl/pbu_top.sv */
// Playback unit: requested time counter, delayed fetch, remap and register slave.
//
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pbu_top
	import pbu_pkg::*;
#(
	parameter logic [31:0] BITS_PER_SEC = PBU_BPS_DEF
)(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              ce,
	input  wire logic              processor_ref_clock,
	input  wire logic              processor_second_tick,
	input  wire pbu_src_t          src,
	output pbu_fetch_t             fetch,
	output pbu_out_t               play,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [PBU_AW-1:0] awaddr,
	input  wire logic [2:0]        awprot,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [PBU_AW-1:0] araddr,
	input  wire logic [2:0]        arprot,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp
);
	// ==========================================================
	// Helpers
	function automatic pbu_time_t pbu_step(input pbu_time_t t);
		pbu_time_t r;
		r = t;
		if (t.bitn == BITS_PER_SEC - 32'h1) begin
			r.bitn = '0;
			r.sec  = t.sec + 32'h1;
		end else begin
			r.bitn = t.bitn + 32'h1;
		end
		return r;
	endfunction

	// The delay may reach a whole second either way, one borrow or carry covers it.
	function automatic pbu_time_t pbu_offs(input pbu_time_t t, input logic signed [31:0] d);
		pbu_time_t          r;
		logic signed [33:0] b;
		r = t;
		b = $signed({2'h0, t.bitn}) - $signed({{2{d[31]}}, d});
		if (b < 0) begin
			b     = b + $signed({2'h0, BITS_PER_SEC});
			r.sec = t.sec - 32'h1;
		end else if (b >= $signed({2'h0, BITS_PER_SEC})) begin
			b     = b - $signed({2'h0, BITS_PER_SEC});
			r.sec = t.sec + 32'h1;
		end
		r.bitn = b[31:0];
		return r;
	endfunction

	function automatic logic pbu_mapped(input logic [PBU_AW-1:0] a);
		return (a[1:0] == 2'h0) && ((a <= PBU_A_ROTBIT) || (a[7:5] == PBU_A_ROUTE));
	endfunction

	// ==========================================================
	// Pin synchronisers
	logic [PBU_SYNC_N-1:0] refc_sync_r;
	logic [PBU_SYNC_N-1:0] tick_sync_r;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			refc_sync_r <= '0;
			tick_sync_r <= '0;
		end else if (ce) begin
			refc_sync_r <= {refc_sync_r[PBU_SYNC_N-2:0], processor_ref_clock};
			tick_sync_r <= {tick_sync_r[PBU_SYNC_N-2:0], processor_second_tick};
		end
	end

	wire ref_edge  = refc_sync_r[1] & ~refc_sync_r[2];
	wire tick_edge = tick_sync_r[1] & ~tick_sync_r[2];

	// ==========================================================
	// Control registers
	logic                   run_r;
	logic                   arm_r;
	logic                   loaded_r;
	logic                   dly_pend_r;
	logic [31:0]            load_sec_r;
	logic [31:0]            active_r;
	logic [31:0]            select_r;
	logic signed [31:0]     dly_r;
	logic signed [31:0]     dly_new_r;
	logic [PBU_STEP_W-1:0]  step_r;
	logic [PBU_FRAC_W-1:0]  frac_r;
	logic [PBU_SW-1:0]      route_r [PBU_NS];
	pbu_time_t              rot_r;

	// ==========================================================
	// Register bus state
	logic              aw_have_r;
	logic              w_have_r;
	logic [PBU_AW-1:0] wa_r;
	logic [31:0]       wd_r;
	logic [3:0]        ws_r;
	logic [31:0]       rd_word;

	wire wr_fire  = aw_have_r & w_have_r & ~bvalid;
	wire rd_take  = arvalid & arready;
	wire wr_ctrl  = wr_fire & (wa_r == PBU_A_CTRL);
	wire wr_route = wr_fire & (wa_r[7:5] == PBU_A_ROUTE) & (wa_r[1:0] == 2'h0);
	wire [31:0] wr_val = pbu_wmask(32'h0, wd_r, ws_r);

	// ==========================================================
	// Requested time counter
	wire [PBU_STEP_W-1:0] frac_sum = {1'b0, frac_r} + step_r;
	wire do_load  = arm_r & tick_edge; // RULE8 RULE9
	wire adv      = ref_edge & loaded_r & frac_sum[PBU_FRAC_W]; // RULE1
	wire rot_wrap = adv & (rot_r.bitn == BITS_PER_SEC - 32'h1);
	wire apply    = do_load | rot_wrap;

	pbu_time_t rot_step;
	pbu_time_t load_time;
	pbu_time_t rot_nxt;
	pbu_time_t fetch_nxt;
	wire signed [31:0] dly_use = dly_pend_r ? dly_new_r : dly_r;

	assign rot_step  = pbu_step(rot_r);
	assign load_time = {load_sec_r, 32'h0};
	assign rot_nxt   = do_load ? load_time : rot_step;
	// Fetch time runs alongside the counter, re-derived only at second boundaries.
	assign fetch_nxt = do_load ? pbu_offs(load_time, dly_use) : // RULE7
		(rot_wrap && dly_pend_r) ? pbu_offs(rot_step, dly_new_r) : // RULE21
		pbu_step(fetch.t); // RULE2 RULE3 RULE6

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rot_r    <= '0;
			frac_r   <= '0;
			loaded_r <= 1'b0;
		end else if (ce) begin
			if (do_load) begin
				rot_r    <= rot_nxt;
				frac_r   <= '0;
				loaded_r <= 1'b1;
			end else if (ref_edge && loaded_r) begin
				frac_r <= frac_sum[PBU_FRAC_W-1:0];
				if (adv) begin
					rot_r <= rot_nxt;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dly_r <= '0;
		end else if (ce && apply && dly_pend_r) begin
			dly_r <= dly_new_r; // RULE21
		end
	end

	// ==========================================================
	// Fetch request and output pipeline
	logic p1_req_r;
	logic p1_rep_r;
	logic p2_req_r;
	logic p2_rep_r;
	logic p2_stb_r;
	wire [PBU_NS-1:0] xbar_y;
	wire [PBU_NS*PBU_SW-1:0] sel_flat;

	genvar gi;
	generate
		for (gi = 0; gi < PBU_NS; gi++) begin : g_sel
			assign sel_flat[gi*PBU_SW +: PBU_SW] = route_r[gi];
		end
	endgenerate

	pbu_xbar u_xbar (
		.src (src.data),
		.en  (active_r & select_r), // RULE10 RULE18
		.sel (sel_flat),
		.y   (xbar_y)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fetch    <= '0;
			p1_req_r <= 1'b0;
			p1_rep_r <= 1'b0;
		end else if (ce) begin
			if (do_load || adv) begin
				fetch.t <= fetch_nxt;
			end
			fetch.strobe <= adv & run_r; // RULE11 RULE13
			p1_req_r     <= do_load | (adv & (rot_nxt.bitn == 32'h0));
			p1_rep_r     <= adv & run_r & (fetch_nxt.bitn == 32'h0); // RULE4 RULE20
		end
	end

	// Storage answers one cycle after the fetch; both ticks wait with it.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			p2_req_r <= 1'b0;
			p2_rep_r <= 1'b0;
			p2_stb_r <= 1'b0;
		end else if (ce) begin
			p2_req_r <= p1_req_r;
			p2_rep_r <= p1_rep_r;
			p2_stb_r <= fetch.strobe;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			play <= '0;
		end else if (ce) begin
			play.requested_tick <= p2_req_r;
			play.replayed_tick  <= p2_rep_r & run_r; // RULE3
			play.stream_clk     <= p2_stb_r & run_r; // RULE15
			if (!run_r) begin
				play.stream <= '0; // RULE13
				play.valid  <= 1'b0;
			end else if (p2_stb_r) begin
				play.stream <= xbar_y; // RULE14
				play.valid  <= src.ok; // RULE5 RULE12
			end
		end
	end

	// ==========================================================
	// Register writes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r      <= 1'b0;
			load_sec_r <= '0;
			dly_new_r  <= '0;
			step_r     <= PBU_STEP_ONE;
			active_r   <= '0;
			select_r   <= '0;
		end else if (ce && wr_fire) begin
			case (wa_r)
				PBU_A_CTRL: begin
					if (ws_r[0]) begin
						run_r <= wd_r[PBU_CTRL_RUN]; // RULE11 RULE13
					end
				end
				PBU_A_SEC:    load_sec_r <= pbu_wmask(load_sec_r, wd_r, ws_r);
				PBU_A_DELAY:  dly_new_r  <= pbu_wmask(dly_new_r, wd_r, ws_r); // RULE2
				PBU_A_STEP: begin
					// Above one bit per reference cycle would skip bits, so it saturates.
					if (wr_val[PBU_STEP_W-1:0] > PBU_STEP_ONE || wr_val[31:PBU_STEP_W] != '0) begin
						step_r <= PBU_STEP_ONE;
					end else begin
						step_r <= wr_val[PBU_STEP_W-1:0]; // RULE1
					end
				end
				PBU_A_ACTIVE: active_r <= pbu_wmask(active_r, wd_r, ws_r); // RULE18
				PBU_A_SELECT: select_r <= pbu_wmask(select_r, wd_r, ws_r); // RULE10
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arm_r      <= 1'b0;
			dly_pend_r <= 1'b0;
		end else if (ce) begin
			if (do_load) begin
				arm_r <= 1'b0;
			end
			if (apply) begin
				dly_pend_r <= 1'b0;
			end
			if (wr_ctrl && ws_r[0] && wd_r[PBU_CTRL_LOAD]) begin
				arm_r <= 1'b1; // RULE8
			end
			if (wr_fire && wa_r == PBU_A_DELAY) begin
				dly_pend_r <= 1'b1; // RULE21
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < PBU_NS; i++) begin
				route_r[i] <= PBU_SW'(i);
			end
		end else if (ce && wr_route) begin
			for (int j = 0; j < 4; j++) begin
				if (ws_r[j]) begin
					route_r[{wa_r[4:2], 2'(j)}] <= wd_r[j*8 +: PBU_SW]; // RULE22
				end
			end
		end
	end

	// ==========================================================
	// Register bus handshakes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awready   <= 1'b1;
			wready    <= 1'b1;
			wa_r      <= '0;
			wd_r      <= '0;
			ws_r      <= '0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_have_r <= 1'b1;
				awready   <= 1'b0;
				wa_r      <= awaddr;
			end
			if (wvalid && wready) begin
				w_have_r <= 1'b1;
				wready   <= 1'b0;
				wd_r     <= wdata;
				ws_r     <= wstrb;
			end
			if (wr_fire) begin
				aw_have_r <= 1'b0;
				w_have_r  <= 1'b0;
				awready   <= 1'b1;
				wready    <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= PBU_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				bvalid <= 1'b1;
				bresp  <= pbu_mapped(wa_r) ? PBU_OKAY : PBU_SLVERR;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Register reads
	always_comb begin
		rd_word = '0;
		case (araddr)
			PBU_A_CTRL:   rd_word[PBU_CTRL_RUN] = run_r;
			PBU_A_STAT: begin
				rd_word[PBU_ST_LOADED] = loaded_r;
				rd_word[PBU_ST_ARMED]  = arm_r;
				rd_word[PBU_ST_DPEND]  = dly_pend_r;
				rd_word[PBU_ST_VALID]  = play.valid;
			end
			PBU_A_SEC:    rd_word = load_sec_r;
			PBU_A_DELAY:  rd_word = dly_new_r;
			PBU_A_STEP:   rd_word = {15'h0, step_r};
			PBU_A_ACTIVE: rd_word = active_r;
			PBU_A_SELECT: rd_word = select_r;
			PBU_A_ROTSEC: rd_word = rot_r.sec;
			PBU_A_ROTBIT: rd_word = rot_r.bitn;
			default: begin
				if (pbu_mapped(araddr)) begin
					for (int k = 0; k < 4; k++) begin
						rd_word[k*8 +: PBU_SW] = route_r[{araddr[4:2], 2'(k)}];
					end
				end
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
			rdata   <= '0;
			rresp   <= PBU_OKAY;
		end else if (ce) begin
			if (rd_take) begin
				rvalid  <= 1'b1;
				arready <= 1'b0;
				rdata   <= rd_word;
				rresp   <= pbu_mapped(araddr) ? PBU_OKAY : PBU_SLVERR;
			end else if (rvalid && rready) begin
				rvalid  <= 1'b0;
				arready <= 1'b1;
			end
		end
	end
endmodule

/* verif/pbu_top_sva.sv */
// Concurrent checks on the playback unit's fetch and output ports.
`timescale 1ns/1ps
module pbu_top_sva
	import pbu_pkg::*;
#(
	parameter logic [31:0] BITS_PER_SEC = PBU_BPS_DEF
)(
	input wire logic       aclk,
	input wire logic       aresetn,
	input wire pbu_src_t   src,
	input wire pbu_fetch_t fetch,
	input wire pbu_out_t   play
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ==========================================================
	// Properties
	property p_fetch_play; fetch.strobe |=> ##1 play.stream_clk; endproperty
	a_fetch_play: assert property (p_fetch_play) else $error("no output bit after fetch");
	property p_valid_src; fetch.strobe |=> ##1 (play.valid == $past(src.ok)); endproperty
	a_valid_src: assert property (p_valid_src) else $error("valid not from answer");
	property p_rep_tick; play.replayed_tick |-> play.stream_clk && $past(fetch.t.bitn, 2) == 0;
	endproperty
	a_rep_tick: assert property (p_rep_tick) else $error("replayed tick off bit 0");
	property p_hold; play.valid && !play.stream_clk |-> $stable(play.stream); endproperty
	a_hold: assert property (p_hold) else $error("stream moved between bits");
	property p_bit_range; fetch.strobe |-> fetch.t.bitn < BITS_PER_SEC; endproperty
	a_bit_range: assert property (p_bit_range) else $error("bit index out of range");
	// Step saturates at one bit per reference edge, so fetches never crowd together.
	property p_spacing; fetch.strobe |=> (!fetch.strobe) [*3]; endproperty
	a_spacing: assert property (p_spacing) else $error("fetches too close");
	property p_clk_src; play.stream_clk |-> $past(fetch.strobe, 2); endproperty
	a_clk_src: assert property (p_clk_src) else $error("bit update without fetch");
	property p_valid_rise; $rose(play.valid) |-> play.stream_clk; endproperty
	a_valid_rise: assert property (p_valid_rise) else $error("valid rose off a bit");
	// ==========================================================
	// Coverage
	c_zero_delay: cover property (play.replayed_tick && play.requested_tick);
	c_delayed: cover property (play.replayed_tick && !play.requested_tick);
	c_valid_fall: cover property ($fell(play.valid));
endmodule
bind pbu_top pbu_top_sva #(.BITS_PER_SEC(BITS_PER_SEC)) pbu_top_sva_i (
	.aclk(aclk), .aresetn(aresetn), .src(src), .fetch(fetch), .play(play));

/* verif/pbu_store_model.sv */
// Storage model that answers each fetch of the playback unit one cycle later.
`timescale 1ns/1ps
module pbu_store_model
	import pbu_pkg::*;
(
	input  wire logic       aclk,
	input  wire pbu_fetch_t fetch,
	input  wire logic       drop,
	output pbu_src_t        src
);
	// ==========================================================
	// Answer
	// Between answers the lines invert, so a sample taken one cycle late never matches.
	initial src = '0;
	always @(posedge aclk) begin
		if (fetch.strobe === 1'b1) begin
			src.data <= {fetch.t.sec[15:0], fetch.t.bitn[15:0]} ^ 32'h5a3c96e1;
			src.ok   <= !drop;
		end else begin
			src <= ~src;
		end
	end
endmodule

/* verif/test_pbu_top.sv */
// Self-checking bench for the playback unit.
`timescale 1ns/1ps
module test_pbu_top;
	import pbu_pkg::*;
	localparam logic [31:0] BPS = 32'h00000014;
	localparam logic [31:0] S0  = 32'h00000100;
	logic        aclk, aresetn, ref_on, ref_clk, tick, drop;
	logic        awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rd, b;
	logic [1:0]  rs, ph, br;
	int          failures, checks, nreq, nbit, nreq0;
	pbu_src_t    src;
	pbu_fetch_t  fetch;
	pbu_out_t    play;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	pbu_top #(.BITS_PER_SEC(BPS)) pbu_top_i (.aclk(aclk), .aresetn(aresetn), .ce(1'b1),
		.processor_ref_clock(ref_clk), .processor_second_tick(tick), .src(src), .fetch(fetch),
		.play(play), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0),
		.wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid),
		.bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
	pbu_store_model pbu_store_model_i (.aclk(aclk), .fetch(fetch), .drop(drop), .src(src));
	// ==========================================================
	// Clocks and monitor
	always #25 aclk = ~aclk;
	// Reference clock of 400 ns, stopped low while ref_on is low.
	always @(posedge aclk) begin
		if (!ref_on) begin
			ph <= 2'h0;
			ref_clk <= 1'b0;
		end else begin
			ph <= ph + 2'h1;
			if (ph == 2'h3) ref_clk <= ~ref_clk;
		end
	end
	always @(posedge aclk) begin
		if (play.requested_tick === 1'b1) begin
			nreq <= nreq + 1;
			nbit <= 0;
		end else if (play.stream_clk === 1'b1) begin
			nbit <= nbit + 1;
		end
	end
	// ==========================================================
	// Tasks
	task automatic test_done;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input bit c, input string m);
		checks++;
		if (!c) begin
			failures++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		bit ao, wo, dn;
		ao = 0;
		wo = 0;
		dn = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 60 && !dn; n++) begin
			@(posedge aclk);
			if (ao && wo && bvalid === 1'b1) begin
				dn = 1;
				br = bresp;
				bready <= 1'b0;
			end
			if (!ao && awready === 1'b1) begin
				ao = 1;
				awvalid <= 1'b0;
			end
			if (!wo && wready === 1'b1) begin
				wo = 1;
				wvalid <= 1'b0;
			end
		end
		if (!dn) begin
			chk(0, "write timeout");
			test_done;
		end
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit ao;
		ao = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 60; n++) begin
			@(posedge aclk);
			if (ao && rvalid === 1'b1) begin
				d = rdata;
				r = rresp;
				rready <= 1'b0;
				return;
			end
			if (!ao && arready === 1'b1) begin
				ao = 1;
				arvalid <= 1'b0;
			end
		end
		chk(0, "read timeout");
		test_done;
	endtask
	task automatic wait_rep(output logic [31:0] s);
		for (int n = 0; n < 400; n++) begin
			@(negedge aclk);
			if (play.replayed_tick === 1'b1) begin
				s = play.stream;
				return;
			end
		end
		chk(0, "no replayed tick");
		test_done;
	endtask
	task automatic pulse_tick;
		@(posedge aclk);
		tick <= 1'b1;
		repeat (4) @(posedge aclk);
		tick <= 1'b0;
		repeat (8) @(posedge aclk);
	endtask
	function automatic logic [31:0] pat(input logic [31:0] sc);
		return {sc[15:0], 16'h0000} ^ 32'h5a3c96e1;
	endfunction
	// ==========================================================
	// Scenarios
	task automatic t_regs;
		axi_rd(PBU_A_STAT, rd, rs);
		chk(rd === 32'h00000000, "status reset");
		axi_rd(PBU_A_STEP, rd, rs);
		chk(rd === 32'h00010000, "step reset");
		axi_rd(8'h40, rd, rs);
		chk(rd === 32'h03020100, "route reset");
		axi_rd(8'h24, rd, rs);
		chk(rs === PBU_SLVERR && rd === 32'h00000000, "unmapped read");
		axi_wr(8'h24, 32'h00000001);
		chk(br === PBU_SLVERR, "unmapped write");
		axi_wr(PBU_A_SEC, S0);
		chk(br === PBU_OKAY, "mapped write");
		$display("t_regs done");
	endtask
	task automatic t_load;
		axi_wr(PBU_A_ACTIVE, 32'hffffffff);
		axi_wr(PBU_A_SELECT, 32'hffffffff);
		axi_wr(PBU_A_SEC, S0);
		axi_wr(PBU_A_CTRL, 32'h00000003);
		axi_rd(PBU_A_STAT, rd, rs);
		chk(rd[PBU_ST_ARMED] === 1'b1, "not armed");
		nreq0 = nreq;
		pulse_tick;
		axi_rd(PBU_A_ROTSEC, rd, rs);
		chk(rd === S0, "loaded second");
		axi_rd(PBU_A_ROTBIT, rd, rs);
		chk(rd === 32'h00000000, "loaded bit");
		ref_on <= 1'b1;
		repeat (30) @(posedge aclk);
		ref_on <= 1'b0;
		repeat (8) @(posedge aclk);
		axi_rd(PBU_A_ROTBIT, b, rs);
		chk(b !== 32'h00000000 && b < BPS, "no counting");
		pulse_tick;
		axi_wr(PBU_A_DELAY, 32'h00000000);
		axi_rd(PBU_A_ROTBIT, rd, rs);
		chk(rd === b, "bit disturbed");
		axi_rd(PBU_A_ROTSEC, rd, rs);
		chk(rd === S0, "second disturbed");
		$display("t_load done");
	endtask
	task automatic t_delay(input int d);
		logic [31:0] s;
		logic [31:0] sc;
		axi_wr(PBU_A_DELAY, 32'(d));
		wait_rep(s);
		wait_rep(s);
		sc = S0 + 32'(nreq - nreq0) - 32'(d > 0);
		chk(s === pat(sc), "stream at replayed tick");
		chk(play.valid === 1'b1, "valid low");
		if (d == 0) chk(play.requested_tick === 1'b1, "ticks apart");
		else chk(nbit === (d > 0 ? d - 1 : int'(BPS) + d - 1), "delay");
		$display("t_delay %0d done", d);
	endtask
	task automatic t_route;
		logic [31:0] s;
		logic [31:0] e;
		axi_wr(PBU_A_ACTIVE, 32'h0000ffff);
		axi_wr(PBU_A_SELECT, 32'hfffffffe);
		axi_wr(8'h40, 32'h00001f05);
		wait_rep(s);
		wait_rep(s);
		e = pat(S0 + 32'(nreq - nreq0));
		chk(s === {16'h0000, e[15:4], 3'b000, e[5]}, "remap");
		$display("t_route done");
	endtask
	task automatic t_valid;
		logic [31:0] s;
		@(posedge aclk);
		drop <= 1'b1;
		wait_rep(s);
		chk(play.valid === 1'b0, "valid with bad data");
		@(posedge aclk);
		drop <= 1'b0;
		$display("t_valid done");
	endtask
	task automatic t_rate(input logic [31:0] st, input int ex);
		int c;
		axi_wr(PBU_A_STEP, st);
		repeat (40) @(posedge aclk);
		c = 0;
		repeat (128) begin
			@(negedge aclk);
			if (play.stream_clk === 1'b1) c++;
		end
		chk(c === ex, "rate");
		$display("t_rate done");
	endtask
	task automatic t_stop;
		int c;
		ref_on <= 1'b0;
		repeat (40) @(posedge aclk);
		axi_wr(PBU_A_CTRL, 32'h00000000);
		@(negedge aclk);
		chk(play.stream === 32'h0 && play.valid === 1'b0, "output after stop");
		@(posedge aclk);
		ref_on <= 1'b1;
		c = 0;
		repeat (80) begin
			@(negedge aclk);
			if (fetch.strobe === 1'b1) c++;
		end
		chk(c === 0, "fetch after stop");
		$display("t_stop done");
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		{aclk, aresetn, ref_on, tick, drop} = 5'h00;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 48'h0;
		{failures, checks, nreq, nreq0} = 128'h0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs;
		t_load;
		ref_on <= 1'b1;
		t_delay(3);
		t_delay(10);
		t_delay(-10);
		t_delay(0);
		t_route;
		t_valid;
		t_rate(32'h00008000, 8);
		t_rate(32'h00020000, 16);
		t_rate(32'h00010000, 16);
		t_stop;
		test_done;
	end
endmodule
